// File: pscf_bus_arbiter_model.sv
// Internal bus arbiter model standing for DMA and the external bus interface
`timescale 1ns/10ps

module pscf_bus_arbiter_model
  import pscf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [NUM_BUS-1:0] bus_request,
  input wire logic [3:0] grant_lag,
  output logic [NUM_BUS-1:0] bus_grant
);
  // ===========================================================================
  // Grant withheld for grant_lag cycles, as if another master held the bus
  logic [3:0] wait_r;

  always_ff @(posedge clk_sys) begin
    if (reset || bus_request == '0) begin
      wait_r <= 4'h0;
      bus_grant <= '0;
    end else if (wait_r >= grant_lag) begin
      bus_grant <= bus_request;
    end else begin
      wait_r <= wait_r + 4'h1;
      bus_grant <= '0;
    end
  end
endmodule

// File: pscf_bus_select.sv
// Shared constants and the internal bus selector for the pipeline control block
`timescale 1ns/10ps

package pscf_pkg;
  // ===========================================================================
  // Pipeline stages
  localparam int STAGES = 6;
  localparam int ST_FETCH = 0;
  localparam int ST_DECODE = 1;
  localparam int ST_INTEGER = 2;
  localparam int ST_ACCESS = 3;
  localparam int ST_EXEC1 = 4;
  localparam int ST_EXEC2 = 5;

  // ===========================================================================
  // Internal buses and address map
  localparam int NUM_BUS = 4;
  localparam logic [1:0] BUS_SEL_0 = 2'h0;
  localparam logic [1:0] BUS_SEL_1 = 2'h1;
  localparam logic [1:0] BUS_SEL_2 = 2'h2;
  localparam logic [1:0] BUS_SEL_V = 2'h3;
  localparam logic [31:0] BUS0_HI = 32'h0000FFFF;
  localparam logic [31:0] BUS1_LO = 32'h00080000;
  localparam logic [31:0] BUS1_HI = 32'h0008FFFF;
  localparam logic [31:0] BUS2_LO = 32'h00100000;
  localparam logic [31:0] BUS2_HI = 32'h0010FFFF;
  localparam logic [31:0] EXT_LO = 32'h01C00000;

  // ===========================================================================
  // Stall cycle counts
  localparam logic [2:0] CNT_COMPUTE = 3'h1;
  localparam logic [2:0] CNT_LOAD_INT = 3'h1;
  localparam logic [2:0] CNT_INTEGER_ADDRESS_UNIT_LOAD = 3'h4;
  localparam logic [2:0] CNT_COND_COMPUTE = 3'h3;
  localparam logic [2:0] CNT_COND_OTHER = 3'h1;
  localparam logic [2:0] CNT_LOAD_RETURN = 3'h2;

  // ===========================================================================
  // Register map and reset values
  localparam logic [7:0] REG_MASK = 8'h00;
  localparam logic [7:0] REG_LATCH = 8'h04;
  localparam logic [7:0] REG_RETURN = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int GIE_BIT = 0;
  localparam logic [31:0] RETURN_RESET = 32'h00000000;
  localparam logic [31:0] INT_VECTOR_BASE = 32'h00000100;
  localparam logic [31:0] EXC_VECTOR_ADDR = 32'h00000080;
  localparam int VECTOR_SHIFT = 4;

  typedef enum logic {INTR_IDLE, INTR_FLOW} pscf_intr_type;
endpackage

// ===========================================================================
// Bus selection by address
module pscf_bus_select
  import pscf_pkg::*;
(
  input wire logic [31:0] addr,
  input wire logic is_virtual,
  output logic [1:0] bus_sel,
  output logic is_ext
);
  always_comb begin
    bus_sel = BUS_SEL_V;
    is_ext = 1'b0;
    if (is_virtual) begin
      bus_sel = BUS_SEL_V;
    end else if (addr <= BUS0_HI) begin
      bus_sel = BUS_SEL_0;
    end else if (addr >= BUS1_LO && addr <= BUS1_HI) begin
      bus_sel = BUS_SEL_1;
    end else if (addr >= BUS2_LO && addr <= BUS2_HI) begin
      bus_sel = BUS_SEL_2;
    end else if (addr >= EXT_LO) begin
      is_ext = 1'b1;
    end
  end
endmodule

// File: pscf_control.sv
// Pipeline interlock, flush and interrupt redirect control
//
// Design decisions made here: strobed register access and the one-cycle delayed mask for pending interrupts.
`timescale 1ns/10ps

module pscf_control
  import pscf_pkg::*;
#(
  parameter int NUM_IRQ = 8,
  parameter logic [31:0] INT_VECTOR = INT_VECTOR_BASE,
  parameter logic [31:0] EXC_VECTOR = EXC_VECTOR_ADDR
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [NUM_IRQ-1:0] irq_in,
  input wire logic [31:0] next_fetch_pc,
  input wire logic fetch_spec,
  input wire logic dep_compute,
  input wire logic dep_load_compute,
  input wire logic dep_load_integer_address_unit,
  input wire logic dep_store_ext,
  input wire logic dep_cond_integer_address_unit,
  input wire logic cond_is_compute,
  input wire logic dec_mem_req,
  input wire logic dec_mem_load,
  input wire logic dec_mem_virtual,
  input wire logic [31:0] dec_mem_addr,
  input wire logic [NUM_BUS-1:0] bus_grant,
  input wire logic load_data_return,
  input wire logic br_resolve,
  input wire logic br_mispredict,
  input wire logic [31:0] br_target,
  input wire logic exc_at_ex2,
  input wire logic rti_done,
  output wire logic [STAGES-1:0] stage_valid,
  output wire logic [STAGES-1:0] stage_intr,
  output logic [31:0] fetch_addr,
  output logic stall_hold,
  output logic [NUM_BUS-1:0] bus_request,
  output logic mem_execute,
  output logic integer_address_unit_update,
  output logic fetch_redirect,
  output logic [31:0] redirect_addr
);
  localparam int IDX_W = (NUM_IRQ > 1) ? $clog2(NUM_IRQ) : 1;

  logic sv_r [STAGES];
  logic ss_r [STAGES];
  logic si_r [STAGES];
  logic sf_r [STAGES];
  logic [31:0] spc_r [STAGES];
  logic sv_nxt [STAGES];
  logic ss_nxt [STAGES];
  logic si_nxt [STAGES];
  logic sf_nxt [STAGES];
  logic [31:0] spc_nxt [STAGES];
  logic [STAGES-1:0] abort;
  logic [NUM_IRQ:0] mask_r;
  logic [NUM_IRQ:0] mask_dly_r;
  logic [NUM_IRQ-1:0] latch_r;
  logic [NUM_IRQ-1:0] pend;
  logic [IDX_W-1:0] irq_idx;
  logic [31:0] interrupt_return_address_r;
  logic [31:0] vec_addr;
  logic [31:0] redir_nxt;
  pscf_intr_type flow_r;
  logic take, exc_go, gie_abort, mis_go, redir_go;
  logic [1:0] dec_sel;
  logic dec_ext;
  logic i_load_r, i_ext_r, i_waited_r;
  logic granted, bw_stall, hz_stall, hold_d, d_adv, d_ok;
  logic slow_load_r, slow_ext_r, slow_set, slow_ext_set, wait_dep, new_hz, hz_done_r;
  logic [2:0] hz_n;
  logic [2:0] hz_cnt_r;
  logic [2:0] ret_cnt_r;
  logic [31:0] rdata_r;

  pscf_bus_select u_bus_select (
    .addr(dec_mem_addr),
    .is_virtual(dec_mem_virtual),
    .bus_sel(dec_sel),
    .is_ext(dec_ext)
  );

  // ===========================================================================
  // Bus request and grant
  assign granted = |(bus_request & bus_grant);
  assign bw_stall = (|bus_request) & ~granted;
  assign slow_set = granted & i_load_r & (i_ext_r | i_waited_r);
  assign slow_ext_set = granted & i_load_r & i_ext_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_request <= '0;
    end else if (d_adv) begin
      bus_request <= '0;
      if (d_ok && !abort[ST_DECODE] && dec_mem_req) begin
        bus_request[dec_sel] <= 1'b1;
      end
    end else if (granted || abort[ST_INTEGER]) begin
      bus_request <= '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      i_load_r <= 1'b0;
      i_ext_r <= 1'b0;
      i_waited_r <= 1'b0;
      mem_execute <= 1'b0;
      integer_address_unit_update <= 1'b0;
    end else begin
      mem_execute <= granted;
      integer_address_unit_update <= d_adv & d_ok & ~abort[ST_DECODE] & dec_mem_req;
      if (d_adv) begin
        i_load_r <= dec_mem_load & dec_mem_req;
        i_ext_r <= dec_ext;
        i_waited_r <= 1'b0;
      end else if (bw_stall) begin
        i_waited_r <= 1'b1;
      end
    end
  end

  // ===========================================================================
  // Load return tracking
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      slow_load_r <= 1'b0;
      slow_ext_r <= 1'b0;
      ret_cnt_r <= 3'h0;
    end else begin
      if (slow_set) begin
        slow_load_r <= 1'b1;
      end else if (load_data_return) begin
        slow_load_r <= 1'b0;
      end
      if (slow_ext_set) begin
        slow_ext_r <= 1'b1;
      end else if (load_data_return) begin
        slow_ext_r <= 1'b0;
      end
      if (load_data_return && slow_load_r && !slow_set) begin
        ret_cnt_r <= CNT_LOAD_RETURN;
      end else if (ret_cnt_r != 3'h0) begin
        ret_cnt_r <= ret_cnt_r - 3'h1;
      end
    end
  end

  // ===========================================================================
  // Dependency stalls
  assign d_ok = sv_r[ST_DECODE];

  always_comb begin
    hz_n = 3'h0; // Plain integer results and stores use the bypass
    if (dep_load_integer_address_unit) begin
      hz_n = CNT_INTEGER_ADDRESS_UNIT_LOAD;
    end else if (dep_cond_integer_address_unit) begin
      hz_n = cond_is_compute ? CNT_COND_COMPUTE : CNT_COND_OTHER;
    end else if (dep_compute) begin
      hz_n = CNT_COMPUTE;
    end else if (dep_load_compute) begin
      hz_n = CNT_LOAD_INT;
    end
  end

  assign wait_dep = (dep_load_compute & (slow_load_r | slow_set | (ret_cnt_r != 3'h0)))
    | (dep_store_ext & (slow_ext_r | slow_ext_set));
  assign new_hz = d_ok & (hz_n != 3'h0) & ~hz_done_r & (hz_cnt_r == 3'h0) & ~wait_dep;
  assign hz_stall = d_ok & (wait_dep | (hz_cnt_r != 3'h0) | new_hz);
  assign hold_d = hz_stall | bw_stall;
  assign d_adv = ~hold_d;

  always_ff @(posedge clk_sys) begin
    if (reset || abort[ST_DECODE]) begin
      hz_cnt_r <= 3'h0;
    end else if (hz_cnt_r != 3'h0) begin
      hz_cnt_r <= hz_cnt_r - 3'h1;
    end else if (new_hz) begin
      hz_cnt_r <= hz_n - 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || abort[ST_DECODE] || d_adv) begin
      hz_done_r <= 1'b0;
    end else if (wait_dep || (new_hz && hz_n == 3'h1) || hz_cnt_r == 3'h1) begin
      hz_done_r <= 1'b1;
    end
  end

  // ===========================================================================
  // Interrupt and exception flow
  always_comb begin
    irq_idx = '0;
    for (int k = NUM_IRQ - 1; k >= 0; k--) begin
      if (pend[k]) begin
        irq_idx = IDX_W'(k);
      end
    end
  end

  assign pend = latch_r & (mask_r[NUM_IRQ:1] | mask_dly_r[NUM_IRQ:1]);
  assign vec_addr = INT_VECTOR + (32'(irq_idx) << VECTOR_SHIFT);
  assign exc_go = exc_at_ex2 & sv_r[ST_EXEC2];
  assign gie_abort = ~exc_go & (flow_r == INTR_FLOW) & sv_r[ST_EXEC1] & si_r[ST_EXEC1]
    & sf_r[ST_EXEC1] & ~mask_r[GIE_BIT];
  assign mis_go = ~exc_go & ~gie_abort & br_resolve & br_mispredict & sv_r[ST_EXEC2] & ~si_r[ST_EXEC2];
  assign take = ~exc_go & ~gie_abort & ~mis_go & (flow_r == INTR_IDLE)
    & mask_r[GIE_BIT] & (|pend);
  assign redir_go = exc_go | gie_abort | (mis_go & (flow_r == INTR_IDLE)) | take;

  always_comb begin
    redir_nxt = vec_addr;
    if (exc_go) begin
      redir_nxt = EXC_VECTOR;
    end else if (gie_abort) begin
      redir_nxt = interrupt_return_address_r;
    end else if (mis_go) begin
      redir_nxt = br_target;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fetch_redirect <= 1'b0;
      redirect_addr <= RETURN_RESET;
      interrupt_return_address_r <= RETURN_RESET;
      flow_r <= INTR_IDLE;
    end else begin
      fetch_redirect <= redir_go;
      if (redir_go) begin
        redirect_addr <= redir_nxt;
      end
      if (take) begin
        interrupt_return_address_r <= spc_r[ST_FETCH];
        flow_r <= INTR_FLOW;
      end else if (mis_go && flow_r == INTR_FLOW) begin
        interrupt_return_address_r <= br_target;
      end
      if (gie_abort || rti_done) begin
        flow_r <= INTR_IDLE;
      end
    end
  end

  // ===========================================================================
  // Stage contents
  generate
    for (genvar g = 0; g < STAGES; g++) begin : g_stage
      assign abort[g] = (exc_go & (g != ST_EXEC2)) | (gie_abort & si_r[g])
        | (mis_go & ss_r[g] & ~si_r[g]) | (take & (g == ST_FETCH));
      assign stage_valid[g] = sv_r[g];
      assign stage_intr[g] = si_r[g];
      if (g == ST_FETCH) begin : g_fetch
        always_comb begin
          sv_nxt[g] = sv_r[g] & ~abort[g];
          ss_nxt[g] = ss_r[g];
          si_nxt[g] = si_r[g];
          sf_nxt[g] = sf_r[g];
          spc_nxt[g] = spc_r[g];
          if (redir_go) begin
            sv_nxt[g] = 1'b1;
            spc_nxt[g] = redir_nxt;
            ss_nxt[g] = 1'b0;
            si_nxt[g] = take;
            sf_nxt[g] = take;
          end else if (!hold_d) begin
            sv_nxt[g] = 1'b1;
            spc_nxt[g] = next_fetch_pc;
            ss_nxt[g] = fetch_spec;
            si_nxt[g] = si_r[g] & (flow_r == INTR_FLOW);
            sf_nxt[g] = 1'b0;
          end
        end
      end else begin : g_later
        logic keep_s;
        logic bub_s;
        assign keep_s = (g == ST_DECODE && hold_d) || (g == ST_INTEGER && bw_stall);
        assign bub_s = (g == ST_INTEGER && hz_stall) || (g == ST_ACCESS && bw_stall);
        always_comb begin
          sv_nxt[g] = sv_r[g-1] & ~abort[g-1];
          ss_nxt[g] = ss_r[g-1];
          si_nxt[g] = si_r[g-1];
          sf_nxt[g] = sf_r[g-1];
          spc_nxt[g] = spc_r[g-1];
          if (keep_s) begin
            sv_nxt[g] = sv_r[g] & ~abort[g];
            ss_nxt[g] = ss_r[g];
            si_nxt[g] = si_r[g];
            sf_nxt[g] = sf_r[g];
            spc_nxt[g] = spc_r[g];
          end else if (bub_s) begin
            sv_nxt[g] = 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < STAGES; i++) begin
      if (reset) begin
        sv_r[i] <= 1'b0;
        ss_r[i] <= 1'b0;
        si_r[i] <= 1'b0;
        sf_r[i] <= 1'b0;
        spc_r[i] <= RETURN_RESET;
      end else begin
        sv_r[i] <= sv_nxt[i];
        ss_r[i] <= ss_nxt[i];
        si_r[i] <= si_nxt[i];
        sf_r[i] <= sf_nxt[i];
        spc_r[i] <= spc_nxt[i];
      end
    end
  end

  assign fetch_addr = spc_r[ST_FETCH];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stall_hold <= 1'b0;
    end else begin
      stall_hold <= hold_d;
    end
  end

  // ===========================================================================
  // Register port
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mask_r <= '0;
      mask_dly_r <= '0;
      latch_r <= '0;
    end else begin
      mask_dly_r <= mask_r;
      if (reg_wr && reg_addr == REG_MASK) begin
        mask_r <= reg_wdata[NUM_IRQ:0];
      end
      latch_r <= (latch_r & ~((reg_wr && reg_addr == REG_LATCH) ? reg_wdata[NUM_IRQ-1:0] : '0)
        & ~(take ? (NUM_IRQ'(1) << irq_idx) : '0)) | irq_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= '0;
      if (reg_rd && reg_addr == REG_MASK) begin
        rdata_r <= 32'(mask_r);
      end else if (reg_rd && reg_addr == REG_LATCH) begin
        rdata_r <= 32'(latch_r);
      end else if (reg_rd && reg_addr == REG_RETURN) begin
        rdata_r <= interrupt_return_address_r;
      end else if (reg_rd && reg_addr == REG_STATUS) begin
        rdata_r <= {27'h0, slow_ext_r, slow_load_r, flow_r == INTR_FLOW, hz_stall, bw_stall};
      end
    end
  end

  assign reg_rdata = rdata_r;

  // ===========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_bus_req_hold: assert property ((bw_stall && !abort[ST_INTEGER]) |=> bus_request == $past(bus_request))
    else $error("bus request dropped before grant");
  a_update_not_waiting: assert property ((d_adv && d_ok && !abort[ST_DECODE] && dec_mem_req)
    |=> (integer_address_unit_update && bus_request != '0))
    else $error("integer update missing beside request");
  a_wait_holds_lines: assert property ((bw_stall && !redir_go) |=> ($stable(spc_r[ST_DECODE])
    && $stable(spc_r[ST_INTEGER]) && !sv_r[ST_ACCESS]))
    else $error("lines moved during bus wait");
  a_one_cycle_stall: assert property ((new_hz && hz_n == 3'h1 && !abort[ST_DECODE])
    |=> (hz_done_r && hz_cnt_r == 3'h0))
    else $error("single stall not exactly one cycle");
  a_integer_address_unit_four_stall: assert property ((new_hz && dep_load_integer_address_unit && !abort[ST_DECODE]) |=> hz_cnt_r == 3'h3)
    else $error("integer load use stall count wrong");
  a_cond_three_stall: assert property ((new_hz && !dep_load_integer_address_unit && dep_cond_integer_address_unit && cond_is_compute
    && !abort[ST_DECODE]) |=> hz_cnt_r == 3'h2)
    else $error("conditional bypass stall count wrong");
  a_return_wait: assert property ((load_data_return && slow_load_r && !slow_set) |=> ret_cnt_r == 3'h2)
    else $error("post return wait not two cycles");
  a_store_ext_wait: assert property ((d_ok && dep_store_ext && slow_ext_r) |-> !d_adv)
    else $error("store passed before load data returned");
  a_take_redirect: assert property (take |=> (fetch_redirect && redirect_addr == $past(vec_addr)
    && interrupt_return_address_r == $past(spc_r[ST_FETCH]) && (!$past(sv_r[ST_FETCH] && d_adv) || !sv_r[ST_DECODE])))
    else $error("interrupt redirect or return address wrong");
  a_gie_blocks: assert property ((reg_wr && reg_addr == REG_MASK && !reg_wdata[GIE_BIT]) |=> !take)
    else $error("interrupt taken after global disable");
  a_gie_recheck: assert property (gie_abort |=> (flow_r == INTR_IDLE && redirect_addr == $past(interrupt_return_address_r)))
    else $error("interrupt flow not aborted on recheck");
  a_mispredict_return: assert property ((mis_go && flow_r == INTR_FLOW) |=> interrupt_return_address_r == $past(br_target))
    else $error("return address not branch target");
  a_exc_flush: assert property (exc_go |=> (!sv_r[ST_DECODE] && !sv_r[ST_INTEGER] && !sv_r[ST_ACCESS]
    && !sv_r[ST_EXEC1] && redirect_addr == EXC_VECTOR))
    else $error("exception flush incomplete");

  c_bus_wait: cover property (bw_stall [*2]);
  c_take: cover property (take);
  c_mispredict_in_flow: cover property (mis_go && flow_r == INTR_FLOW);
  c_exception: cover property (exc_go);
endmodule

// File: pscf_control_tb_top.sv
// Self-checking testbench for the pipeline stall and flush control
`timescale 1ns/10ps

module pscf_control_tb_top
  import pscf_pkg::*;
();
  logic clk_sys, reset, reg_wr, reg_rd, fetch_spec, dep_compute, dep_load_compute, dep_load_integer_address_unit;
  logic dep_store_ext, dep_cond_integer_address_unit, cond_is_compute, dec_mem_req, dec_mem_load, dec_mem_virtual;
  logic load_data_return, br_resolve, br_mispredict, exc_at_ex2, rti_done, stall_hold, mem_execute;
  logic integer_address_unit_update, fetch_redirect;
  logic [7:0] reg_addr, irq_in;
  logic [31:0] reg_wdata, reg_rdata, next_fetch_pc, dec_mem_addr, br_target, fetch_addr, redirect_addr;
  logic [3:0] bus_grant, bus_request, grant_lag;
  logic [5:0] stage_valid, stage_intr;
  int bad_count, comparisons, cycles;

  pscf_control pscf_control_inst (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_in(irq_in),
    .next_fetch_pc(next_fetch_pc), .fetch_spec(fetch_spec), .dep_compute(dep_compute),
    .dep_load_compute(dep_load_compute), .dep_load_integer_address_unit(dep_load_integer_address_unit), .dep_store_ext(dep_store_ext),
    .dep_cond_integer_address_unit(dep_cond_integer_address_unit), .cond_is_compute(cond_is_compute), .dec_mem_req(dec_mem_req),
    .dec_mem_load(dec_mem_load), .dec_mem_virtual(dec_mem_virtual), .dec_mem_addr(dec_mem_addr),
    .bus_grant(bus_grant), .load_data_return(load_data_return), .br_resolve(br_resolve),
    .br_mispredict(br_mispredict), .br_target(br_target), .exc_at_ex2(exc_at_ex2), .rti_done(rti_done),
    .stage_valid(stage_valid), .stage_intr(stage_intr), .fetch_addr(fetch_addr), .stall_hold(stall_hold),
    .bus_request(bus_request), .mem_execute(mem_execute), .integer_address_unit_update(integer_address_unit_update),
    .fetch_redirect(fetch_redirect), .redirect_addr(redirect_addr));

  pscf_bus_arbiter_model pscf_bus_arbiter_model_inst (.clk_sys(clk_sys), .reset(reset),
    .bus_request(bus_request), .grant_lag(grant_lag), .bus_grant(bus_grant));

  // ===========================================================================
  // Clock, timeout and reporting
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ===========================================================================
  // Register bus and helpers
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #5 d = reg_rdata;
  endtask

  // Counts a run of held cycles; decoder flags drop once decode moves on
  task automatic count_stall(input bit patient, output int n);
    n = 0;
    for (int i = 0; i < 14; i++) begin
      @(posedge clk_sys);
      #5;
      if (stall_hold === 1'b1) begin
        n++;
      end else begin
        {dep_compute, dep_load_compute, dep_load_integer_address_unit, dep_store_ext, dep_cond_integer_address_unit} <= 5'h00;
        if (n > 0 || !patient) break;
      end
    end
  endtask

  task automatic wait_redirect(input int lim);
    for (int i = 0; i < lim && fetch_redirect !== 1'b1; i++) begin
      @(posedge clk_sys);
      #5;
    end
  endtask

  // ===========================================================================
  // Scenarios
  task automatic regs_after_reset();
    logic [31:0] d;
    reg_read(REG_MASK, d);
    cmp_val(d, 32'h00000000);
    reg_write(REG_RETURN, 32'h00001234);
    reg_read(REG_RETURN, d);
    cmp_val(d, RETURN_RESET);
    reg_read(8'h10, d);
    cmp_val(d, 32'h00000000);
    cmp_val(32'(stage_valid[1:0]), 32'h00000003);
  endtask

  task automatic bus_case(input logic [31:0] a, input logic virt, input logic [3:0] exp, input logic [3:0] lag);
    int w;
    @(posedge clk_sys);
    grant_lag <= lag;
    dec_mem_req <= 1'b1;
    dec_mem_load <= 1'b0;
    dec_mem_virtual <= virt;
    dec_mem_addr <= a;
    @(posedge clk_sys);
    dec_mem_req <= 1'b0;
    #5;
    cmp_val(32'(bus_request), 32'(exp));
    cmp_val(32'(integer_address_unit_update), 32'h00000001);
    for (w = 0; w < 20 && mem_execute !== 1'b1; w++) begin
      @(posedge clk_sys);
      #5;
      if (w == 0 && lag > 0) cmp_val(32'(stall_hold), 32'h00000001);
    end
    cmp_cnt(w, lag + 2);
    cmp_val(32'(bus_request), 32'h00000000);
  endtask

  task automatic stall_table();
    int n;
    for (int k = 0; k < 6; k++) begin
      repeat (3) @(posedge clk_sys);
      dep_compute <= (k == 0);
      dep_load_compute <= (k == 1);
      dep_load_integer_address_unit <= (k == 2);
      dep_cond_integer_address_unit <= (k == 3 || k == 4);
      cond_is_compute <= (k == 3);
      count_stall(k == 5, n);
      case (k)
        0: cmp_cnt(n, int'(CNT_COMPUTE));
        1: cmp_cnt(n, int'(CNT_LOAD_INT));
        2: cmp_cnt(n, int'(CNT_INTEGER_ADDRESS_UNIT_LOAD));
        3: cmp_cnt(n, int'(CNT_COND_COMPUTE));
        4: cmp_cnt(n, int'(CNT_COND_OTHER));
        default: cmp_cnt(n, 0);
      endcase
    end
  endtask

  task automatic slow_dep(input logic store, output int n);
    @(posedge clk_sys);
    grant_lag <= 4'h0;
    dec_mem_req <= 1'b1;
    dec_mem_load <= 1'b1;
    dec_mem_virtual <= 1'b0;
    dec_mem_addr <= EXT_LO;
    @(posedge clk_sys);
    dec_mem_req <= 1'b0;
    dep_store_ext <= store;
    dep_load_compute <= !store;
    repeat (6) @(posedge clk_sys);
    #5;
    cmp_val(stall_hold, 1'b1);
    @(posedge clk_sys);
    load_data_return <= 1'b1;
    @(posedge clk_sys);
    load_data_return <= 1'b0;
    count_stall(1'b0, n);
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic irq_flow();
    logic [31:0] d;
    @(posedge clk_sys);
    next_fetch_pc <= 32'h00000440;
    reg_write(REG_MASK, 32'h00000009);
    @(posedge clk_sys);
    irq_in <= 8'h06;
    @(posedge clk_sys);
    irq_in <= 8'h00;
    wait_redirect(6);
    cmp_val(redirect_addr, INT_VECTOR_BASE + (32'h2 << VECTOR_SHIFT));
    reg_read(REG_RETURN, d);
    cmp_val(d, 32'h00000440);
    @(posedge clk_sys);
    br_resolve <= 1'b1;
    br_mispredict <= 1'b1;
    br_target <= 32'h00000A00;
    @(posedge clk_sys);
    br_resolve <= 1'b0;
    br_mispredict <= 1'b0;
    #5;
    cmp_val(32'(|stage_intr), 32'h00000001);
    reg_read(REG_RETURN, d);
    cmp_val(d, 32'h00000A00);
    @(posedge clk_sys);
    rti_done <= 1'b1;
    @(posedge clk_sys);
    rti_done <= 1'b0;
    reg_write(REG_MASK, 32'h00000004);
    wait_redirect(8);
    cmp_val(32'(fetch_redirect), 32'h00000000);
    reg_write(REG_MASK, 32'h00000005);
    wait_redirect(6);
    cmp_val(redirect_addr, INT_VECTOR_BASE + (32'h1 << VECTOR_SHIFT));
    reg_write(REG_MASK, 32'h00000004);
    #5;
    wait_redirect(10);
    cmp_val(redirect_addr, 32'h00000440);
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic exception_flush();
    // Let valid lines refill the second execute stage after the recheck abort
    repeat (2) @(posedge clk_sys);
    @(posedge clk_sys);
    exc_at_ex2 <= 1'b1;
    @(posedge clk_sys);
    exc_at_ex2 <= 1'b0;
    #5;
    cmp_val(32'(stage_valid), 32'h00000001);
    cmp_val(redirect_addr, EXC_VECTOR_ADDR);
    cmp_val(fetch_addr, EXC_VECTOR_ADDR);
  endtask

  // ===========================================================================
  // Main sequence
  initial begin
    int na, nb;
    reset = 1'b1;
    {reg_wr, reg_rd, fetch_spec, dep_compute, dep_load_compute, dep_load_integer_address_unit} = 6'h00;
    {dep_store_ext, dep_cond_integer_address_unit, cond_is_compute, dec_mem_req, dec_mem_load, dec_mem_virtual} = 6'h00;
    {load_data_return, br_resolve, br_mispredict, exc_at_ex2, rti_done} = 5'h00;
    reg_addr = 8'h00;
    irq_in = 8'h00;
    reg_wdata = 32'h00000000;
    next_fetch_pc = 32'h00000200;
    dec_mem_addr = 32'h00000000;
    br_target = 32'h00000000;
    grant_lag = 4'h0;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    regs_after_reset();
    bus_case(BUS0_HI, 1'b0, 4'h1, 4'h0);
    bus_case(BUS1_LO, 1'b0, 4'h2, 4'h2);
    bus_case(BUS2_HI, 1'b0, 4'h4, 4'h1);
    bus_case(EXT_LO, 1'b0, 4'h8, 4'h0);
    bus_case(32'h00000010, 1'b1, 4'h8, 4'h3);
    stall_table();
    slow_dep(1'b0, na);
    slow_dep(1'b1, nb);
    cmp_cnt(na - nb, int'(CNT_LOAD_RETURN));
    irq_flow();
    exception_flush();
    end_sim();
  end
endmodule
